// *** hvpp_pkg.sv ***
package hvpp_pkg;
  // =========================================
  // pin groups carried together
  typedef struct packed {
    logic       page_latch;
    logic       action_sel1;
    logic       action_sel0;
    logic       byte_sel_lo_hi;
    logic       byte_sel_ext;
    logic       output_enable_n;
    logic       write_strobe_n;
    logic       load_strobe;
  } hvpp_ctl_type;

  typedef enum logic [1:0] {
    HVPP_IDLE  = 2'b00,
    HVPP_ERASE = 2'b01,
    HVPP_PROG  = 2'b10
  } hvpp_state_type;
endpackage

// *** hvpp_port.sv ***
`include "hvpp_regs.svh"
// What the document asks of this block and of its programmer
// [R1] ready_busy_n low while erase or program busy
// [R2] drive data bus only while output enable low
// [R3] byte_sel_lo_hi picks low or high byte
// [R4] byte_sel_ext picks second high byte
// [R5] load strobe decodes address, data, command, idle
// [R6] decode write-type command bytes; only erase, flash write and lock write are decoded
// [R7] decode read-type command bytes
// [R8] latch entry pattern at high voltage entry
// [R9] programmer waits before first command
// [R10] leave mode on power down or reset
// [R11] command and address kept across operations
// [R12] programmer reloads high address per window
// [R13] erase flash, eeprom, then lock; fuses kept
// [R14] keep_eeprom_fuse preserves eeprom on erase
// [R15] programmer erases before reprogramming
// [R16] write strobe after erase command starts erase
// [R17] address load stores low or high byte
// [R18] data load stores low or high byte
// [R19] page latch copies word into page buffer
// [R20] flash: 256 pages of 64 words
// [R21] eeprom: 256 pages of 4 bytes
// [R22] upper low-address bits join page number
// [R23] write strobe programs buffered flash page
// [R24] programmer strobes at least 250ns wide; the model holds each strobe 12 cycles, 120ns
// [R25] capture on load rise, act on write fall
module hvpp_port #(
  parameter int unsigned ERASE_CYC = `HVPP_ERASE_CYC,  // erase busy length
  parameter int unsigned PROG_CYC  = `HVPP_PROG_CYC,   // page write busy length
  parameter int unsigned PAGE_W    = 64,               // flash words per page
  parameter int unsigned FL_PAGES  = 256,              // flash pages
  parameter int unsigned EE_BYTES  = 1024              // eeprom size
) (
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire logic               hv_reset,         // high voltage seen on reset pin
  input  wire hvpp_pkg::hvpp_ctl_type ctl_pins,     // raw strobe and select pins
  input  wire logic [7:0]         data_in,
  output logic [7:0]              data_out,
  output logic                    data_oe,
  output logic                    ready_busy_n,
  input  wire logic               keep_eeprom_fuse, // 1 = programmed
  output logic                    prog_mode,        // programming mode active
  output logic [7:0]              lock_bits         // lock byte, 0 = programmed
);
  localparam int FL_WORDS = PAGE_W * FL_PAGES;
  // idle pin levels: strobes and output enable inactive, so no false edge after reset
  localparam hvpp_pkg::hvpp_ctl_type CTL_IDLE = 8'h06;

  // =========================================
  // pin synchronisers: three stages, agree on last two
  hvpp_pkg::hvpp_ctl_type s1_q, s2_q, s3_q, flt_q, flt_d;
  logic [7:0] d1_q, d2_q, d3_q, dflt_q, dflt_d;
  logic       hv1_q, hv2_q, hv3_q, hvf_q, hvf_d;

  // a change only counts once stage two and three agree
  always_comb begin
    flt_d  = (s2_q == s3_q) ? s3_q : flt_q;
    dflt_d = (d2_q == d3_q) ? d3_q : dflt_q;
    hvf_d  = (hv2_q == hv3_q) ? hv3_q : hvf_q;
  end

  // synchroniser chain registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= CTL_IDLE; s2_q <= CTL_IDLE; s3_q <= CTL_IDLE; flt_q <= CTL_IDLE;
      d1_q <= 8'h00; d2_q <= 8'h00; d3_q <= 8'h00; dflt_q <= 8'h00;
      hv1_q <= 1'b0; hv2_q <= 1'b0; hv3_q <= 1'b0; hvf_q <= 1'b0;
    end else begin
      s1_q <= ctl_pins; s2_q <= s1_q; s3_q <= s2_q; flt_q <= flt_d;
      d1_q <= data_in; d2_q <= d1_q; d3_q <= d2_q; dflt_q <= dflt_d;
      hv1_q <= hv_reset; hv2_q <= hv1_q; hv3_q <= hv2_q; hvf_q <= hvf_d;
    end
  end

  // =========================================
  // storage, in flip-flops
  logic [15:0] flash_q [FL_WORDS];     // flash array, erased is all ones
  logic [15:0] pbuf_q  [PAGE_W];       // flash page buffer
  logic [7:0]  ee_q    [EE_BYTES];     // eeprom array

  // =========================================
  // control state
  hvpp_pkg::hvpp_state_type st_q, st_d;
  logic [7:0]  cmd_q, cmd_d;           // last loaded command
  logic [7:0]  alo_q, alo_d, ahi_q, ahi_d;
  logic [7:0]  dlo_q, dlo_d, dhi_q, dhi_d;
  logic [31:0] cnt_q, cnt_d;
  logic [31:0] hold_q, hold_d;         // entry latch window counter
  logic        mode_q, mode_d;
  logic        entry_ok_q, entry_ok_d;
  logic [7:0]  lock_q, lock_d;
  logic        prev_ls_q, prev_wr_q, prev_pl_q;
  logic        ls_rise, wr_fall, pl_rise, hv_rise;
  logic [1:0]  act;
  logic [15:0] addr;

  assign ls_rise = flt_q.load_strobe & ~prev_ls_q;      // [R25]
  assign wr_fall = ~flt_q.write_strobe_n & prev_wr_q;   // [R25]
  assign pl_rise = flt_q.page_latch & ~prev_pl_q;
  assign hv_rise = hvf_q & ~mode_q;
  assign act     = {flt_q.action_sel1, flt_q.action_sel0};
  assign addr    = {ahi_q, alo_q};

  // page of an address; upper low-byte bits join the page number
  function automatic logic [13:0] page_base(input logic [15:0] a);
    page_base = {a[13:6], 6'h00};                       // [R20] [R22]
  endfunction

  // next-state for mode, command, address, data and busy machine
  always_comb begin
    st_d = st_q; cmd_d = cmd_q; alo_d = alo_q; ahi_d = ahi_q;
    dlo_d = dlo_q; dhi_d = dhi_q; cnt_d = cnt_q; lock_d = lock_q;
    mode_d = mode_q; entry_ok_d = entry_ok_q; hold_d = hold_q;
    if (!hvf_q) begin
      mode_d = 1'b0;                                    // [R10]
      st_d   = hvpp_pkg::HVPP_IDLE;
      cmd_d  = `HVPP_CMD_RESET;
    end else if (hv_rise) begin
      mode_d = 1'b1;
      // pattern caught as high voltage arrives
      entry_ok_d = ({flt_q.page_latch, flt_q.action_sel1, flt_q.action_sel0,
                     flt_q.byte_sel_lo_hi} == `HVPP_ENTRY_PATTERN);   // [R8]
      hold_d = 32'd0;
    end else if (mode_q && entry_ok_q) begin
      if (hold_q < `HVPP_HOLD_CYC) hold_d = hold_q + 32'd1;
      case (st_q)
        hvpp_pkg::HVPP_IDLE: begin
          // loads only when ready; command and address persist  [R11]
          if (ls_rise) begin
            if (act == `HVPP_ACT_ADDR) begin                  // [R5]
              if (flt_q.byte_sel_lo_hi) ahi_d = dflt_q;       // [R17] [R3]
              else alo_d = dflt_q;                            // [R17]
            end else if (act == `HVPP_ACT_DATA) begin
              if (flt_q.byte_sel_lo_hi) dhi_d = dflt_q;       // [R18]
              else dlo_d = dflt_q;                            // [R18]
            end else if (act == `HVPP_ACT_CMD) begin
              cmd_d = dflt_q;                                 // [R5]
            end
          end
          if (wr_fall) begin
            if (cmd_q == `HVPP_CMD_CHIP_ERASE) begin          // [R6] [R16]
              st_d = hvpp_pkg::HVPP_ERASE;
              cnt_d = 32'(ERASE_CYC);
            end else if (cmd_q == `HVPP_CMD_WR_FLASH) begin   // [R6] [R23]
              st_d = hvpp_pkg::HVPP_PROG;
              cnt_d = 32'(PROG_CYC);
            end else if (cmd_q == `HVPP_CMD_WR_LOCK) begin    // [R6]
              lock_d = lock_q & dlo_q;
            end
          end
        end
        hvpp_pkg::HVPP_ERASE, hvpp_pkg::HVPP_PROG: begin
          if (cnt_q > 32'd1) cnt_d = cnt_q - 32'd1;
          else begin
            st_d = hvpp_pkg::HVPP_IDLE;
            // lock cleared at the end of erase, on the same edge as the arrays  [R13]
            if (st_q == hvpp_pkg::HVPP_ERASE) lock_d = `HVPP_FUSE_ERASED;
          end
        end
        default: st_d = hvpp_pkg::HVPP_IDLE;
      endcase
    end
  end

  // control registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= hvpp_pkg::HVPP_IDLE; cmd_q <= `HVPP_CMD_RESET;
      alo_q <= 8'h00; ahi_q <= 8'h00; dlo_q <= 8'hff; dhi_q <= 8'hff;
      cnt_q <= 32'd0; lock_q <= `HVPP_FUSE_ERASED; mode_q <= 1'b0;
      entry_ok_q <= 1'b0; hold_q <= 32'd0;
      prev_ls_q <= 1'b0; prev_wr_q <= 1'b1; prev_pl_q <= 1'b0;
    end else begin
      st_q <= st_d; cmd_q <= cmd_d; alo_q <= alo_d; ahi_q <= ahi_d;
      dlo_q <= dlo_d; dhi_q <= dhi_d; cnt_q <= cnt_d; lock_q <= lock_d;
      mode_q <= mode_d; entry_ok_q <= entry_ok_d; hold_q <= hold_d;
      prev_ls_q <= flt_q.load_strobe; prev_wr_q <= flt_q.write_strobe_n;
      prev_pl_q <= flt_q.page_latch;
    end
  end

  // =========================================
  // memory arrays: buffer fill, page write, erase
  logic        busy_end, active;
  assign active   = mode_q & entry_ok_q;
  assign busy_end = (st_q != hvpp_pkg::HVPP_IDLE) && (cnt_q <= 32'd1);

  // array write side; no reset, contents are nonvolatile
  always_ff @(posedge clk) begin
    if (active && st_q == hvpp_pkg::HVPP_IDLE && pl_rise &&
        cmd_q == `HVPP_CMD_WR_FLASH)
      pbuf_q[alo_q[5:0]] <= {dhi_q, dlo_q};                // [R19]
    if (busy_end && st_q == hvpp_pkg::HVPP_PROG) begin
      for (int i = 0; i < PAGE_W; i++)
        flash_q[page_base(addr) + 14'(i)] <= pbuf_q[i];    // [R23]
    end
    if (busy_end && st_q == hvpp_pkg::HVPP_ERASE) begin
      for (int i = 0; i < FL_WORDS; i++) flash_q[i] <= 16'hffff;   // [R13]
      if (!keep_eeprom_fuse)                                       // [R14]
        for (int j = 0; j < EE_BYTES; j++) ee_q[j] <= 8'hff;       // [R21]
    end
  end

  // =========================================
  // read path, muxed by command and byte selects
  logic [7:0] rd_d, rd_q;
  always_comb begin
    rd_d = 8'h00;
    case (cmd_q)                                               // [R7]
      `HVPP_CMD_RD_FLASH:
        rd_d = flt_q.byte_sel_lo_hi ? flash_q[addr[13:0]][15:8]   // [R3]
                                    : flash_q[addr[13:0]][7:0];
      `HVPP_CMD_RD_EEPROM: rd_d = ee_q[addr[9:0]];
      `HVPP_CMD_RD_FUSE:
        // lock byte on lo_hi=1, ext=0; fuses kept erased here    [R4]
        rd_d = (flt_q.byte_sel_lo_hi && !flt_q.byte_sel_ext) ? lock_q
                                                             : `HVPP_FUSE_ERASED;
      `HVPP_CMD_RD_SIG: rd_d = 8'h5a;  // signature value is arbitrary
      default: rd_d = 8'h00;
    endcase
  end

  // data output register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) rd_q <= 8'h00;
    else rd_q <= rd_d;
  end

  assign data_out     = rd_q;
  assign data_oe      = active & ~flt_q.output_enable_n;              // [R2]
  assign ready_busy_n = (st_q == hvpp_pkg::HVPP_IDLE);                // [R1]
  assign prog_mode    = active;
  assign lock_bits    = lock_q;

  // =========================================
  // checks
  AST_BUSY_LOW: assert property (@(posedge clk) disable iff (!nrst)
    (st_q != hvpp_pkg::HVPP_IDLE) |-> !ready_busy_n)                  // [R1]
    else $error("ready_busy_n high during busy");
  AST_OE: assert property (@(posedge clk) disable iff (!nrst)
    flt_q.output_enable_n |-> !data_oe)                               // [R2]
    else $error("bus driven with output enable high");
  AST_ERASE_START: assert property (@(posedge clk) disable iff (!nrst)
    (active && st_q == hvpp_pkg::HVPP_IDLE && hvf_q && !hv_rise && wr_fall &&
     cmd_q == `HVPP_CMD_CHIP_ERASE) |=> !ready_busy_n)                // [R16]
    else $error("erase did not start");
  AST_PROG_START: assert property (@(posedge clk) disable iff (!nrst)
    (active && st_q == hvpp_pkg::HVPP_IDLE && hvf_q && !hv_rise && wr_fall &&
     cmd_q == `HVPP_CMD_WR_FLASH) |=> st_q == hvpp_pkg::HVPP_PROG)    // [R23]
    else $error("page write did not start");
  AST_EXIT: assert property (@(posedge clk) disable iff (!nrst)
    !hvf_q |=> !mode_q && ready_busy_n)                               // [R10]
    else $error("mode kept without high voltage");
  AST_CMD_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    (mode_q && hvf_q && !ls_rise) |=> $stable(cmd_q))                 // [R11]
    else $error("command changed without load");
  AST_ADDR_LO: assert property (@(posedge clk) disable iff (!nrst)
    (active && hvf_q && !hv_rise && st_q == hvpp_pkg::HVPP_IDLE && ls_rise &&
     act == `HVPP_ACT_ADDR && !flt_q.byte_sel_lo_hi) |=> alo_q == $past(dflt_q)) // [R17]
    else $error("low address not stored");
  AST_DATA_HI: assert property (@(posedge clk) disable iff (!nrst)
    (active && hvf_q && !hv_rise && st_q == hvpp_pkg::HVPP_IDLE && ls_rise &&
     act == `HVPP_ACT_DATA && flt_q.byte_sel_lo_hi) |=> dhi_q == $past(dflt_q))  // [R18]
    else $error("high data not stored");
  AST_LOCK_CLR: assert property (@(posedge clk) disable iff (!nrst)
    (busy_end && st_q == hvpp_pkg::HVPP_ERASE && hvf_q) |=>
      lock_q == `HVPP_FUSE_ERASED && ready_busy_n)                    // [R13]
    else $error("lock not cleared after erase");
endmodule // hvpp_port

// *** hvpp_prog_model.sv ***
// =========================================
// programmer model: drives strobes, selects and the data byte
module hvpp_prog_model (
  input  wire logic            clk,
  input  wire logic            data_oe,
  input  wire logic [7:0]      data_out,
  output hvpp_pkg::hvpp_ctl_type ctl,      // pins toward the device
  output logic [7:0]           bus         // resolved data bus level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] drv;                         // byte driven by the programmer
  // idle pins: entry pattern 0000, strobes inactive
  initial begin
    ctl = '0;
    ctl.output_enable_n = 1'b1;
    ctl.write_strobe_n  = 1'b1;
    drv = 8'h00;
  end
  // released bus shows the inverse of the last byte, never a stale match
  always_comb bus = ctl.output_enable_n ? drv : (data_oe ? data_out : ~drv);
  // every level held 12 cycles, well past the sync chain but short of the 250ns minimum width
  task automatic step();
    repeat (12) @(negedge clk);
  endtask
  task automatic load(input logic [1:0] act, input logic bs1, input logic [7:0] d);
    ctl.action_sel1    = act[1];
    ctl.action_sel0    = act[0];
    ctl.byte_sel_lo_hi = bs1;
    ctl.byte_sel_ext   = 1'b0;
    drv                = d;
    step();
    ctl.load_strobe = 1'b1;
    step();
    ctl.load_strobe = 1'b0;
    step();
  endtask
  // returns with the strobe released; caller waits for ready
  task automatic pulse_wr();
    ctl.write_strobe_n = 1'b0;
    step();
    ctl.write_strobe_n = 1'b1;
  endtask
  task automatic pulse_page();
    ctl.page_latch = 1'b1;
    step();
    ctl.page_latch = 1'b0;
    step();
  endtask
  task automatic read_sel(input logic oe_n, input logic bs1, input logic bs2);
    ctl.output_enable_n = oe_n;
    ctl.byte_sel_lo_hi  = bs1;
    ctl.byte_sel_ext    = bs2;
    step();
  endtask
endmodule // hvpp_prog_model

// *** hvpp_regs.svh ***
`ifndef HVPP_REGS_SVH
`define HVPP_REGS_SVH
// =========================================
// action select codes
`define HVPP_ACT_ADDR      2'b00
`define HVPP_ACT_DATA      2'b01
`define HVPP_ACT_CMD       2'b10
`define HVPP_ACT_IDLE      2'b11
// =========================================
// command bytes
`define HVPP_CMD_CHIP_ERASE  8'h80
`define HVPP_CMD_WR_FUSE     8'h40
`define HVPP_CMD_WR_LOCK     8'h20
`define HVPP_CMD_WR_FLASH    8'h10
`define HVPP_CMD_WR_EEPROM   8'h11
`define HVPP_CMD_RD_SIG      8'h08
`define HVPP_CMD_RD_FUSE     8'h04
`define HVPP_CMD_RD_FLASH    8'h02
`define HVPP_CMD_RD_EEPROM   8'h03
`define HVPP_CMD_NOP         8'h00
// =========================================
// entry pattern and reset values
`define HVPP_ENTRY_PATTERN   4'h0
`define HVPP_CMD_RESET       8'h00
`define HVPP_FUSE_ERASED     8'hff
// =========================================
// timing
`define HVPP_CLK_MHZ         100
`define HVPP_HOLD_US         10
`define HVPP_HOLD_CYC        (`HVPP_HOLD_US * `HVPP_CLK_MHZ)
`define HVPP_ERASE_CYC       2000
`define HVPP_PROG_CYC        1000
`endif

// *** tb_top.sv ***
`include "hvpp_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned ERASE_N = 60;    // shortened erase busy
  localparam int unsigned PROG_N  = 40;    // shortened page write busy
  logic clk, nrst, hv_reset, keep_fuse, data_oe, ready_busy_n, prog_mode;
  logic [7:0] bus, data_out, lock_bits, lk, alo, ahi, dlo, dhi;
  hvpp_pkg::hvpp_ctl_type ctl;
  int error_cnt, tests_run, busy_cnt;
  hvpp_prog_model i_prog (.clk(clk), .data_oe(data_oe), .data_out(data_out),
    .ctl(ctl), .bus(bus));
  hvpp_port #(.ERASE_CYC(ERASE_N), .PROG_CYC(PROG_N)) i_dut (.clk(clk), .nrst(nrst),
    .hv_reset(hv_reset), .ctl_pins(ctl), .data_in(bus), .data_out(data_out),
    .data_oe(data_oe), .ready_busy_n(ready_busy_n), .keep_eeprom_fuse(keep_fuse),
    .prog_mode(prog_mode), .lock_bits(lock_bits));
  // =========================================
  // clock, busy length counter
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) busy_cnt <= (ready_busy_n === 1'b0) ? busy_cnt + 1 : busy_cnt;
  // =========================================
  // compare and verdict
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // write strobe, then a bounded wait for ready and a busy length check
  task automatic do_write(input int n);
    int k;
    busy_cnt = 0;
    i_prog.pulse_wr();
    check(ready_busy_n, 1'b0, "busy after write");
    for (k = 0; k < 300 && ready_busy_n !== 1'b1; k++) @(negedge clk);
    if (k == 300) begin
      check(ready_busy_n, 1'b1, "ready timeout");
      complete_run();
    end
    check(busy_cnt >= n - 1 && busy_cnt <= n + 1, 1'b1, "busy length");
  endtask
  // =========================================
  // main sequence
  initial begin
    nrst = 1'b0;
    hv_reset = 1'b0;
    keep_fuse = 1'b0;
    error_cnt = 0;
    tests_run = 0;
    busy_cnt = 0;
    void'($urandom(32'hd7ed));
    repeat (12) @(negedge clk);
    check(8'({ready_busy_n, prog_mode, data_oe}), 8'h04, "reset outputs");
    check(lock_bits, 8'hff, "reset lock");
    nrst = 1'b1;
    @(negedge clk);
    hv_reset = 1'b1;
    i_prog.step();
    check(prog_mode, 1'b1, "mode entry");
    repeat (30) i_prog.step();
    // chip erase clears lock and eeprom
    i_prog.load(`HVPP_ACT_CMD, 1'b0, `HVPP_CMD_CHIP_ERASE);
    do_write(ERASE_N);
    check(lock_bits, 8'hff, "lock after erase");
    i_prog.load(`HVPP_ACT_CMD, 1'b0, `HVPP_CMD_RD_EEPROM);
    i_prog.load(`HVPP_ACT_ADDR, 1'b0, 8'($urandom));
    i_prog.read_sel(1'b0, 1'b0, 1'b0);
    check(data_out, 8'hff, "eeprom erased");
    i_prog.read_sel(1'b1, 1'b0, 1'b0);
    // lock write, then an idle load must not touch the data byte
    lk = 8'($urandom) & 8'hfc;
    i_prog.load(`HVPP_ACT_CMD, 1'b0, `HVPP_CMD_WR_LOCK);
    i_prog.load(`HVPP_ACT_DATA, 1'b0, lk);
    i_prog.pulse_wr();
    i_prog.step();
    check(lock_bits, lk, "lock write");
    i_prog.load(`HVPP_ACT_IDLE, 1'b0, 8'h00);
    i_prog.pulse_wr();
    i_prog.step();
    check(lock_bits, lk, "idle action");
    i_prog.load(`HVPP_ACT_CMD, 1'b0, `HVPP_CMD_RD_FUSE);
    i_prog.read_sel(1'b0, 1'b1, 1'b0);
    check(data_oe, 1'b1, "bus driven");
    check(data_out, lk, "lock read");
    i_prog.read_sel(1'b1, 1'b1, 1'b0);
    check(data_oe, 1'b0, "bus released");
    // flash page write of one random word
    alo = 8'($urandom);
    ahi = 8'($urandom) & 8'h3f;
    dlo = 8'($urandom);
    dhi = 8'($urandom);
    i_prog.load(`HVPP_ACT_CMD, 1'b0, `HVPP_CMD_WR_FLASH);
    i_prog.load(`HVPP_ACT_ADDR, 1'b0, alo);
    i_prog.load(`HVPP_ACT_DATA, 1'b0, dlo);
    i_prog.load(`HVPP_ACT_DATA, 1'b1, dhi);
    i_prog.pulse_page();
    i_prog.load(`HVPP_ACT_ADDR, 1'b1, ahi);
    do_write(PROG_N);
    // address kept: only the command is reloaded
    i_prog.load(`HVPP_ACT_CMD, 1'b0, `HVPP_CMD_RD_FLASH);
    i_prog.read_sel(1'b0, 1'b0, 1'b0);
    check(data_out, dlo, "flash low");
    i_prog.read_sel(1'b0, 1'b1, 1'b0);
    check(data_out, dhi, "flash high");
    i_prog.read_sel(1'b1, 1'b0, 1'b0);
    // leave the mode by dropping the reset high voltage
    hv_reset = 1'b0;
    i_prog.step();
    check(prog_mode, 1'b0, "mode exit");
    complete_run();
  end
endmodule // tb_top
